// file: common/drt_bank_if.sv
// Purpose: Command and status bundle between the decoder and one bank tracker.
// Assumes: One instance per bank.
// Notes:   Commands are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface drt_bank_if #(parameter int ROW_W = 14);
  logic             act;
  logic             pre;
  logic             ap_rd;
  logic             ap_wr;
  logic [ROW_W-1:0] new_row;
  logic             impl_en;
  logic [7:0]       trp;
  logic [7:0]       trtp;
  logic [5:0]       tras;
  logic [7:0]       wr_dly;
  logic             is_open;
  logic             busy;
  logic [ROW_W-1:0] row;
  modport ctrl (output act, pre, ap_rd, ap_wr, new_row, impl_en, trp, trtp, tras, wr_dly,
                input is_open, busy, row);
  modport bank (input act, pre, ap_rd, ap_wr, new_row, impl_en, trp, trtp, tras, wr_dly,
                output is_open, busy, row);
endinterface
`default_nettype wire

// file: common/drt_params.svh
// Purpose: Register map, field positions, reset values and pin positions of the row command block.
// Assumes: 32-bit register data on a plain strobe port, byte addresses on word boundaries.
// Notes:   Definitions only.
`ifndef DRT_PARAMS_SVH
`define DRT_PARAMS_SVH
`define DRT_ADDR_CFG   8'h00
`define DRT_ADDR_TIM   8'h04
`define DRT_ADDR_WRT   8'h08
`define DRT_ADDR_STAT  8'h0C
`define DRT_ADDR_BUSY  8'h10
`define DRT_CFG_PAR    0
`define DRT_CFG_PC     1
`define DRT_TIM_TRP    7:0
`define DRT_TIM_TRTP   15:8
`define DRT_TIM_TRAS   21:16
`define DRT_WRT_WR     4:0
`define DRT_WRT_WL     12:8
`define DRT_WRT_BL4    16
`define DRT_STAT_PERR  16
`define DRT_TRP_RST    8'h0E
`define DRT_TRTP_RST   8'h04
`define DRT_TRAS_RST   6'h21
`define DRT_WR_RST     5'h10
`define DRT_WL_RST     5'h02
`define DRT_CMD_NOP    3'h7
`define DRT_CMD_PRE    3'h3
`define DRT_CMD_ACT    2'h2
`define DRT_R_ALL      4
`define DRT_R_BA4      3
`define DRT_CNT_ONE    8'h01
`define DRT_RAS_FIRST  6'h01
`define DRT_BL2_HALF   8'h01
`define DRT_BL4_HALF   8'h02
`endif

// file: common/drt_pkg.sv
// Purpose: Shared types of the row command block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Bank state encoding is left to the tools.
`default_nettype none
package drt_pkg;
  typedef enum logic [2:0] {
    DRT_IDLE,
    DRT_ACTIVE,
    DRT_AP_WAIT,
    DRT_IMPRE,
    DRT_PRECH
  } drt_bank_state_t;
endpackage
`default_nettype wire

// file: rtl/drt_bank.sv
// Purpose: State and timers of one bank: open, auto precharge wait, implicit and explicit precharge.
// Assumes: The host keeps its own spacing rules; commands arrive decoded and qualified.
// Notes:   The wait counter loads the programmed cycle count, the row-active counter starts at one; a zero count behaves as one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "drt_params.svh"
module drt_bank #(parameter int ROW_W = 14) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Bank command bundle
  drt_bank_if.bank b
);
  import drt_pkg::*;
  drt_bank_state_t  state_reg, state_next;
  logic [7:0]       cnt_reg, cnt_next;
  logic [5:0]       ras_reg;
  logic [ROW_W-1:0] row_reg;
  logic             ras_clr;
  wire              cnt_done = cnt_reg <= `DRT_CNT_ONE;
  wire              ras_met  = ras_reg >= b.tras;
  wire              row_diff = b.new_row != row_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg - ((cnt_reg == 8'h00) ? 8'h00 : `DRT_CNT_ONE);
    ras_clr    = 1'b0;
    case (state_reg)
      DRT_IDLE: begin
        if (b.act) begin
          state_next = DRT_ACTIVE;
          ras_clr    = 1'b1;
        end
      end
      DRT_ACTIVE: begin
        if (b.pre) begin
          state_next = DRT_PRECH;
          cnt_next   = b.trp;
        end else if (b.act && b.impl_en && row_diff) begin
          state_next = DRT_IMPRE;
          cnt_next   = b.trp;
        end else if (b.ap_rd) begin
          state_next = DRT_AP_WAIT;
          cnt_next   = b.trtp;
        end else if (b.ap_wr) begin
          state_next = DRT_AP_WAIT;
          cnt_next   = b.wr_dly;
        end
      end
      DRT_AP_WAIT: begin
        // An explicit precharge may overtake the pending auto precharge.
        if (b.pre || (cnt_done && ras_met)) begin
          state_next = DRT_PRECH;
          cnt_next   = b.trp;
        end
      end
      DRT_IMPRE: begin
        if (cnt_done) begin
          state_next = DRT_ACTIVE;
          ras_clr    = 1'b1;
        end
      end
      DRT_PRECH: begin
        if (cnt_done) begin
          state_next = DRT_IDLE;
        end
      end
      default: state_next = DRT_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg <= DRT_IDLE;
      cnt_reg   <= 8'h00;
      ras_reg   <= 6'h00;
      row_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      // The opening edge is the first row-active cycle, so auto precharge can start exactly tRAS after it.
      ras_reg   <= ras_clr ? `DRT_RAS_FIRST : ras_reg + ((ras_reg == 6'h3F) ? 6'h00 : 6'h01);
      if (b.act && (state_reg == DRT_IDLE || (state_reg == DRT_ACTIVE && b.impl_en))) begin
        row_reg <= b.new_row;
      end
    end
  end

  assign b.is_open = (state_reg == DRT_ACTIVE) || (state_reg == DRT_AP_WAIT);
  assign b.busy    = (state_reg == DRT_IMPRE) || (state_reg == DRT_PRECH);
  assign b.row     = row_reg;

  a_pre_nop_idle: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg == DRT_IDLE && b.pre && !b.act) |=> state_reg == DRT_IDLE)
    else $error("Precharge to an idle bank changed its state.");
  a_pre_nop_busy: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg == DRT_PRECH && !cnt_done) |=> state_reg == DRT_PRECH && cnt_reg == $past(cnt_reg) - 8'h01)
    else $error("Precharge in progress was disturbed.");
  a_open_holds: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg == DRT_ACTIVE && !b.pre && !b.ap_rd && !b.ap_wr && !(b.act && b.impl_en && row_diff))
    |=> state_reg == DRT_ACTIVE)
    else $error("Open row closed without a closing command.");
  a_impre_start: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg == DRT_ACTIVE && b.act && b.impl_en && row_diff && !b.pre)
    |=> state_reg == DRT_IMPRE && cnt_reg == $past(b.trp))
    else $error("Implicit precharge not started after the second activate cycle.");
  a_ap_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg == DRT_AP_WAIT && !b.pre && !(cnt_done && ras_met)) |=> state_reg == DRT_AP_WAIT)
    else $error("Auto precharge started before its delay and row time.");
  a_prech_load: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg == DRT_ACTIVE && b.pre) |=> state_reg == DRT_PRECH ##0 cnt_reg == $past(b.trp))
    else $error("Precharge did not load the precharge time.");
  c_impre: cover property (@(posedge i_clk_sys) disable iff (i_srst)
    state_reg == DRT_IMPRE ##1 state_reg == DRT_ACTIVE);
  c_auto_pre: cover property (@(posedge i_clk_sys) disable iff (i_srst)
    state_reg == DRT_AP_WAIT ##1 state_reg == DRT_PRECH);
endmodule
`default_nettype wire

// file: rtl/drt_row_ctrl.sv
// Purpose: Row command decoder of one channel with per-bank row state and precharge timing.
// Assumes: Both halves of a row command cycle arrive together on the rising edge.
// Notes:   Refresh and power commands decode as no action; a neighbouring block owns them.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "drt_params.svh"
module drt_row_ctrl #(
  parameter int N_BANK = 16,
  parameter int ROW_W  = 14,
  parameter bit PC_SEL = 1'b0
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_srst,
  // Row command bus, rising and falling halves
  input  wire logic [5:0]       i_row_rise,
  input  wire logic [5:0]       i_row_fall,
  // Decoded column commands
  input  wire logic             i_col_valid,
  input  wire logic             i_col_write,
  input  wire logic             i_col_ap,
  input  wire logic [3:0]       i_col_bank,
  // Register port
  input  wire logic [7:0]       i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  // Status
  output logic      [N_BANK-1:0] o_bank_open,
  output logic      [N_BANK-1:0] o_bank_busy,
  output logic                  o_parity_err
);
  import drt_pkg::*;

  // Configuration and status registers.
  logic             par_en_reg;
  logic             pc_mode_reg;
  logic [7:0]       trp_reg;
  logic [7:0]       trtp_reg;
  logic [5:0]       tras_reg;
  logic [4:0]       wr_reg;
  logic [4:0]       wl_reg;
  logic             bl4_reg;
  logic             perr_reg;
  logic [31:0]      rdata_reg;
  // Activate first-cycle capture.
  logic             act1_reg;
  logic             act_mine_reg;
  logic [3:0]       act_bank_reg;
  logic [2:0]       act_hi_reg;

  wire w_cfg  = i_wr && (i_addr == `DRT_ADDR_CFG);
  wire w_tim  = i_wr && (i_addr == `DRT_ADDR_TIM);
  wire w_wrt  = i_wr && (i_addr == `DRT_ADDR_WRT);
  wire w_stat = i_wr && (i_addr == `DRT_ADDR_STAT);

  // Command decode. The second activate cycle carries row bits only, so it is never decoded.
  wire [3:0] ba       = {i_row_fall[5], i_row_rise[5:3]};
  wire       ba4      = i_row_fall[`DRT_R_BA4];
  wire       pc_hit   = !pc_mode_reg || (ba4 == PC_SEL);
  wire       cmd_ok   = !act1_reg && pc_hit;
  wire       is_nop   = i_row_rise[2:0] == `DRT_CMD_NOP;
  // An activate for the other pseudo channel still takes two cycles, so its row cycle is skipped as well.
  wire       act_any  = !act1_reg && (i_row_rise[1:0] == `DRT_CMD_ACT);
  wire       act1     = cmd_ok && (i_row_rise[1:0] == `DRT_CMD_ACT);
  wire       pre_cmd  = cmd_ok && (i_row_rise[2:0] == `DRT_CMD_PRE);
  wire       pre_all  = pre_cmd && i_row_fall[`DRT_R_ALL];
  wire       pre_one  = pre_cmd && !i_row_fall[`DRT_R_ALL];
  wire       act2     = act1_reg && act_mine_reg;
  wire [ROW_W-1:0] act_row = ROW_W'({act_hi_reg, i_row_rise, i_row_fall[5:3], i_row_fall[1:0]});
  // Even parity over both halves, the parity pin included.
  wire       par_bad  = par_en_reg && (^{i_row_rise, i_row_fall});
  wire [7:0] bl_half  = bl4_reg ? `DRT_BL4_HALF : `DRT_BL2_HALF;
  wire [7:0] wr_dly   = 8'(wl_reg) + bl_half + 8'(wr_reg);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      act1_reg     <= 1'b0;
      act_mine_reg <= 1'b0;
      act_bank_reg <= 4'h0;
      act_hi_reg   <= 3'h0;
    end else begin
      act1_reg     <= act_any;
      act_mine_reg <= act1;
      if (act1) begin
        act_bank_reg <= ba;
        act_hi_reg   <= {i_row_fall[4], i_row_fall[1:0]};
      end
    end
  end

  // Bank trackers.
  genvar g;
  generate
    for (g = 0; g < N_BANK; g++) begin : gen_bank
      drt_bank_if #(.ROW_W(ROW_W)) bif ();
      assign bif.act     = act2 && (act_bank_reg == 4'(g));
      assign bif.pre     = pre_all || (pre_one && (ba == 4'(g)));
      assign bif.ap_rd   = i_col_valid && i_col_ap && !i_col_write && (i_col_bank == 4'(g));
      assign bif.ap_wr   = i_col_valid && i_col_ap && i_col_write && (i_col_bank == 4'(g));
      assign bif.new_row = act_row;
      assign bif.impl_en = pc_mode_reg;
      assign bif.trp     = trp_reg;
      assign bif.trtp    = trtp_reg;
      assign bif.tras    = tras_reg;
      assign bif.wr_dly  = wr_dly;
      assign o_bank_open[g] = bif.is_open;
      assign o_bank_busy[g] = bif.busy;
      drt_bank #(.ROW_W(ROW_W)) u_bank (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .b         (bif)
      );
    end
  endgenerate

  // Register file.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      par_en_reg  <= 1'b0;
      pc_mode_reg <= 1'b0;
      trp_reg     <= `DRT_TRP_RST;
      trtp_reg    <= `DRT_TRTP_RST;
      tras_reg    <= `DRT_TRAS_RST;
      wr_reg      <= `DRT_WR_RST;
      wl_reg      <= `DRT_WL_RST;
      bl4_reg     <= 1'b0;
    end else begin
      if (w_cfg) begin
        par_en_reg  <= i_wdata[`DRT_CFG_PAR];
        pc_mode_reg <= i_wdata[`DRT_CFG_PC];
      end
      if (w_tim) begin
        trp_reg  <= i_wdata[`DRT_TIM_TRP];
        trtp_reg <= i_wdata[`DRT_TIM_TRTP];
        tras_reg <= i_wdata[`DRT_TIM_TRAS];
      end
      if (w_wrt) begin
        wr_reg  <= i_wdata[`DRT_WRT_WR];
        wl_reg  <= i_wdata[`DRT_WRT_WL];
        bl4_reg <= i_wdata[`DRT_WRT_BL4];
      end
    end
  end

  // A parity error in the same cycle as its clear stays set.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      perr_reg <= 1'b0;
    end else begin
      perr_reg <= par_bad || (perr_reg && !(w_stat && i_wdata[`DRT_STAT_PERR]));
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_addr)
      `DRT_ADDR_CFG: begin
        rd_mux[`DRT_CFG_PAR] = par_en_reg;
        rd_mux[`DRT_CFG_PC]  = pc_mode_reg;
      end
      `DRT_ADDR_TIM: begin
        rd_mux[`DRT_TIM_TRP]  = trp_reg;
        rd_mux[`DRT_TIM_TRTP] = trtp_reg;
        rd_mux[`DRT_TIM_TRAS] = tras_reg;
      end
      `DRT_ADDR_WRT: begin
        rd_mux[`DRT_WRT_WR]  = wr_reg;
        rd_mux[`DRT_WRT_WL]  = wl_reg;
        rd_mux[`DRT_WRT_BL4] = bl4_reg;
      end
      `DRT_ADDR_STAT: begin
        rd_mux[N_BANK-1:0]     = o_bank_open;
        rd_mux[`DRT_STAT_PERR] = perr_reg;
      end
      `DRT_ADDR_BUSY: rd_mux[N_BANK-1:0] = o_bank_busy;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign o_rdata      = rdata_reg;
  assign o_parity_err = perr_reg;

  a_nop_quiet: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (is_nop && !act1_reg) |-> !act1 && !pre_cmd)
    else $error("Row no-operation was decoded as a command.");
  a_nop_keeps: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (is_nop && !act1_reg) |=> (o_bank_open & ~$past(o_bank_open) & ~$past(o_bank_busy)) == '0)
    else $error("Row no-operation opened a bank.");
  a_act_second: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (act1 && !o_bank_open[ba] && !o_bank_busy[ba] && !i_col_valid) |-> ##1 !o_bank_open[$past(ba)] ##1
    o_bank_open[$past(ba, 2)])
    else $error("Bank did not open on the second activate cycle.");
  a_act_no_decode: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    act_any |=> !act1 && !pre_cmd)
    else $error("Second activate cycle was decoded as a command.");
  a_par_flag: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (par_en_reg && (^{i_row_rise, i_row_fall})) |=> o_parity_err)
    else $error("Parity error not flagged.");
  a_par_off: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!par_en_reg && !o_parity_err) |=> !o_parity_err)
    else $error("Parity flagged while checking is off.");
  a_pc_ignore: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (pc_mode_reg && !act1_reg && ba4 != PC_SEL) |-> !act1 && !pre_cmd)
    else $error("Other pseudo channel command was taken.");
  a_rd_window: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("Read data outside its cycle.");
  c_act: cover property (@(posedge i_clk_sys) disable iff (i_srst) act1 ##2 o_bank_open != 0);
  c_pre_all: cover property (@(posedge i_clk_sys) disable iff (i_srst) pre_all && o_bank_open != 0);
  c_perr: cover property (@(posedge i_clk_sys) disable iff (i_srst) $rose(o_parity_err));
endmodule
`default_nettype wire

// file: sim/drt_host_model.sv
// Purpose: Host side of the row and column command buses, one command per request.
// Assumes: The bench keeps every host spacing rule by waiting between requests.
// Notes:   Idle cycles carry row no-operations whose free bits change every cycle.
`timescale 1ns/1ps
`default_nettype none
module drt_host_model (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Request from the bench
  input  wire logic        i_go,
  input  wire logic [2:0]  i_kind,
  input  wire logic [4:0]  i_bank,
  input  wire logic [13:0] i_row,
  input  wire logic [1:0]  i_bad,
  // Command buses
  output logic      [5:0]  o_row_rise,
  output logic      [5:0]  o_row_fall,
  output logic             o_col_valid,
  output logic             o_col_write,
  output logic             o_col_ap,
  output logic      [3:0]  o_col_bank
);
  logic [1:0]  ph;
  logic [2:0]  kd;
  logic [4:0]  ba;
  logic [13:0] ra;
  logic [1:0]  bad;
  logic [5:0]  junk;
  logic [5:0]  rr;
  logic [5:0]  ff;
  always_ff @(posedge i_clk_sys) begin
    junk <= i_srst ? 6'h00 : junk + 6'h05;
    if (i_srst) ph <= 2'h0;
    else if (i_go) begin
      ph  <= 2'h1;
      kd  <= i_kind;
      ba  <= i_bank;
      ra  <= i_row;
      bad <= i_bad;
    end else if (ph == 2'h1 && kd == 3'h0) ph <= 2'h2;
    else ph <= 2'h0;
  end
  always_comb begin
    rr = {junk[5:3], 3'b111};
    ff = {junk[2:0], 1'b0, junk[1:0]};
    if (ph == 2'h1 && kd == 3'h0) begin
      rr = {ba[2:0], 3'b010};
      ff = {ba[3], ra[13], ba[4], 1'b0, ra[12:11]};
    end else if (ph == 2'h2) begin
      rr = ra[10:5];
      ff = {ra[4:2], 1'b0, ra[1:0]};
    end else if (ph == 2'h1 && kd < 3'h3) begin
      rr = {ba[2:0], 3'b011};
      ff = {ba[3], kd == 3'h2, ba[4], 3'b000};
    end
    ff[2] = ^{rr, ff} ^ ((ph == 2'h1) ? bad[0] : (ph == 2'h2) ? bad[1] : 1'b0);
  end
  assign o_row_rise  = rr;
  assign o_row_fall  = ff;
  assign o_col_valid = ph == 2'h1 && kd >= 3'h3;
  assign o_col_write = kd >= 3'h5;
  assign o_col_ap    = kd == 3'h4 || kd == 3'h6;
  assign o_col_bank  = ba[3:0];
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Purpose: Self-checking bench of the row command block against a cycle model of bank state.
// Assumes: Spacing between host commands is kept here by waiting.
// Notes:   Auto precharge start is matched to the exact cycle that tRTP, write recovery and tRAS give.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  kind = 3'h0;
  logic [4:0]  bank = 5'h00;
  logic [13:0] row = 14'h0000;
  logic [1:0]  bad = 2'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [5:0]  rise, fall;
  logic        colv, colw, colap, perr;
  logic [3:0]  colb;
  logic [31:0] rdata;
  logic [15:0] bopen, bbusy;
  int miscompares = 0, cmp_count = 0, cyc = 0, trp = 3, live = 0, pc = 0;
  int eo[16], bl[16], er[16], co[16];
  always #50 clk = ~clk;
  drt_host_model host_u (.i_clk_sys(clk), .i_srst(srst), .i_go(go), .i_kind(kind), .i_bank(bank),
    .i_row(row), .i_bad(bad), .o_row_rise(rise), .o_row_fall(fall), .o_col_valid(colv),
    .o_col_write(colw), .o_col_ap(colap), .o_col_bank(colb));
  drt_row_ctrl dut_u (.i_clk_sys(clk), .i_srst(srst), .i_row_rise(rise), .i_row_fall(fall),
    .i_col_valid(colv), .i_col_write(colw), .i_col_ap(colap), .i_col_bank(colb), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_bank_open(bopen),
    .o_bank_busy(bbusy), .o_parity_err(perr));
  function automatic logic [15:0] bm(bit o);
    for (int i = 0; i < 16; i++) bm[i] = o ? (eo[i] != 0 && bl[i] == 0) : (bl[i] > 0);
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < 16; i++) if (bl[i] > 0) bl[i]--;
  end
  always @(negedge clk) if (live) begin
    chk("bank open", bm(1), bopen);
    chk("bank busy", bm(0), bbusy);
  end
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask
  task automatic cmd(int k, int b, int r, int bd);
    @(posedge clk);
    go   <= 1'b1;
    kind <= k[2:0];
    bank <= b[4:0];
    row  <= r[13:0];
    bad  <= bd[1:0];
    @(posedge clk);
    go   <= 1'b0;
    repeat ((k == 0) ? 2 : 1) @(posedge clk);
    #1;
  endtask
  task automatic act(int b, int r);
    int i;
    cmd(0, b, r, 0);
    i = b % 16;
    if (pc && b >= 16) return;
    if (eo[i] == 0) begin
      eo[i] = 1;
      er[i] = r;
      co[i] = cyc;
    end else if (pc && er[i] != r) begin
      er[i] = r;
      bl[i] = trp;
    end
  endtask
  task automatic pre(int b, int all);
    cmd(all ? 2 : 1, b, 0, 0);
    for (int i = 0; i < 16; i++) if ((all || i == b) && eo[i] && bl[i] == 0) begin
      eo[i] = 0;
      bl[i] = trp;
    end
  endtask
  task automatic apc(int k, int b, int ex);
    int n;
    live = 0;
    cmd(k, b, 0, 0);
    n = 0;
    while (bbusy[b] !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("auto precharge delay", ex, n);
    eo[b] = 0;
    bl[b] = trp;
    live = 1;
    repeat (trp + 2) @(posedge clk);
  endtask
  initial begin
    #(100 * 20000);
    miscompares++;
    summarize();
  end
  initial begin
    int b1, b2, r1, ex;
    for (int i = 0; i < 16; i++) begin
      eo[i] = 0;
      bl[i] = 0;
    end
    void'($urandom(87));
    b1 = $urandom % 16;
    b2 = (b1 + 1 + $urandom % 15) % 16;
    r1 = $urandom % 16384;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rreg(8'h04, 32'h0021040E);
    rreg(8'h08, 32'h00000210);
    wreg(8'h14, 32'hFFFFFFFF);
    rreg(8'h14, 32'h00000000);
    wreg(8'h04, 32'h000C0203);
    rreg(8'h04, 32'h000C0203);
    live = 1;
    $display("test registers done");
    act(b1, r1);
    repeat (4) @(posedge clk);
    act(b2, r1 ^ 1);
    repeat (8) @(posedge clk);
    act(b1, r1 ^ 5);
    pre(b1, 0);
    repeat (trp + 2) @(posedge clk);
    act(b1, r1 ^ 5);
    repeat (12) @(posedge clk);
    rreg(8'h0C, {16'h0000, bm(1)});
    pre(b1, 0);
    pre(b1, 0);
    repeat (trp + 2) @(posedge clk);
    pre(b1, 0);
    pre(0, 1);
    repeat (trp + 2) @(posedge clk);
    $display("test legacy row commands done");
    wreg(8'h00, 32'h00000003);
    pc = 1;
    act(b1 | 16, r1);
    act(b1, r1);
    repeat (14) @(posedge clk);
    act(b1, r1);
    act(b1, r1 ^ 14'h2AAA);
    repeat (trp + 14) @(posedge clk);
    chk("parity clean", 0, perr);
    cmd(0, b2 | 16, r1, 2);
    @(posedge clk);
    #1;
    chk("parity second cycle", 1, perr);
    wreg(8'h0C, 32'h00010000);
    @(posedge clk);
    #1;
    chk("parity cleared", 0, perr);
    cmd(1, b2, 0, 1);
    @(posedge clk);
    #1;
    chk("parity first cycle", 1, perr);
    wreg(8'h0C, 32'h00010000);
    wreg(8'h00, 32'h00000002);
    cmd(1, b2, 0, 1);
    @(posedge clk);
    #1;
    chk("parity disabled", 0, perr);
    $display("test pseudo channel and parity done");
    act(b2, r1);
    cmd(3, b2, 0, 0);
    ex = 12 - (cyc + 3 - co[b2]);
    if (ex < 2) ex = 2;
    apc(4, b2, ex);
    for (int m = 0; m < 2; m++) begin
      wreg(8'h08, {15'h0000, m[0], 16'h0302});
      act(b2, r1);
      repeat (14) @(posedge clk);
      cmd(5, b2, 0, 0);
      apc(6, b2, 2 + 1 + m + 3);
    end
    $display("test auto precharge done");
    summarize();
  end
endmodule
`default_nettype wire
